// File: sser_pkg.sv
/*
 * Shared constants for the status, error and secondary-data register bank:
 * register indices, field positions, reset values and bus answer codes.
 * Assumes a 32-bit AXI4-Lite register bus with one register per word.
 */
package sser_pkg;

    // ----------
    // bus geometry
    // ----------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int IDX_W = 6;
    localparam int IDX_LSB = 2;

    typedef logic [IDX_W-1:0] sser_idx_t;
    typedef logic [7:0] sser_byte_t;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------
    // register indices (byte address is four times the index)
    // ----------
    localparam sser_idx_t IDX_PART_IDENTITY = 6'h00;
    localparam sser_idx_t IDX_ERROR_REPORT = 6'h02;
    localparam sser_idx_t IDX_SENSOR_STATUS = 6'h03;
    localparam sser_idx_t IDX_SECONDARY_X_LOW = 6'h0A;
    localparam sser_idx_t IDX_SECONDARY_X_HIGH = 6'h0B;
    localparam sser_idx_t IDX_SECONDARY_Y_LOW = 6'h0C;
    localparam sser_idx_t IDX_SECONDARY_Y_HIGH = 6'h0D;
    localparam sser_idx_t IDX_SECONDARY_Z_LOW = 6'h0E;
    localparam sser_idx_t IDX_SECONDARY_Z_HIGH = 6'h0F;
    localparam sser_idx_t IDX_SECONDARY_R_LOW = 6'h10;
    localparam sser_idx_t IDX_BANK_CONTROL = 6'h3F;

    localparam int SECONDARY_BYTES = 7;

    // ----------
    // error_report fields
    // ----------
    localparam int ERR_FATAL_BIT = 0;
    localparam int ERR_CMD_BIT = 1;
    localparam int ERR_CODE_LSB = 2;
    localparam int ERR_CODE_MSB = 4;
    localparam int ERR_FIFO_BIT = 6;
    localparam int ERR_AUX_BIT = 7;
    localparam logic [2:0] ERR_CODE_NONE = 3'h0;
    localparam logic [2:0] ERR_CODE_ACCEL_CONF = 3'h1;
    localparam sser_byte_t ERROR_REPORT_RESET = 8'h00;

    // ----------
    // sensor_status fields
    // ----------
    localparam int STAT_MAN_OP_BIT = 2;
    localparam int STAT_CMD_RDY_BIT = 4;
    localparam int STAT_DRDY_SEC_BIT = 5;
    localparam int STAT_DRDY_ACC_BIT = 7;
    localparam sser_byte_t SENSOR_STATUS_RESET = 8'h10;

    // ----------
    // bank_control fields
    // ----------
    localparam int CTRL_SOFT_RESET_BIT = 0;
    localparam sser_byte_t SECONDARY_RESET = 8'h00;

    // neutral identity value, chosen arbitrarily
    localparam sser_byte_t PART_IDENTITY_DEFAULT = 8'h5A;

endpackage

// File: sser_sticky_flag.sv
/*
 * One sticky flag: set by a hardware event, cleared by a read or command.
 * Assumes set and clear are single-cycle pulses on the same clock.
 */
`timescale 1ns/1ns
module sser_sticky_flag (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic set,
    input wire logic clr,
    output logic q
);

    // ----------
    // set beats clear in the same cycle
    // ----------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= 1'b0;
        end else if (set) begin
            q <= 1'b1;
        end else if (clr) begin
            q <= 1'b0;
        end
    end

endmodule

// File: sser_axil_slave.sv
/*
 * AXI4-Lite slave front end: takes address and data in either order,
 * issues one-cycle read and write strobes with a register index.
 * Assumes the register file answers rd_data and decode flags
 * combinationally in the strobe cycle.
 */
`timescale 1ns/1ns
module sser_axil_slave
    import sser_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [sser_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [sser_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [sser_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [sser_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic wr_en,
    output sser_pkg::sser_idx_t wr_idx,
    output logic [7:0] wr_byte,
    output logic wr_lane0,
    input wire logic wr_ok,
    output logic rd_en,
    output sser_pkg::sser_idx_t rd_idx,
    input wire logic [7:0] rd_data,
    input wire logic rd_ok
);

    logic have_aw;
    logic have_w;
    logic ar_take;

    // ----------
    // write channel
    // ----------
    assign wr_en = have_aw && have_w && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            have_aw <= 1'b0;
            s_axi_awready <= 1'b1;
            wr_idx <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            have_aw <= 1'b1;
            s_axi_awready <= 1'b0;
            wr_idx <= s_axi_awaddr[IDX_LSB +: IDX_W];
        end else if (s_axi_bvalid && s_axi_bready) begin
            have_aw <= 1'b0;
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            have_w <= 1'b0;
            s_axi_wready <= 1'b1;
            wr_byte <= '0;
            wr_lane0 <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            have_w <= 1'b1;
            s_axi_wready <= 1'b0;
            wr_byte <= s_axi_wdata[7:0];
            wr_lane0 <= s_axi_wstrb[0];
        end else if (s_axi_bvalid && s_axi_bready) begin
            have_w <= 1'b0;
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_en) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ----------
    // read channel
    // ----------
    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign rd_en = ar_take;
    assign rd_idx = s_axi_araddr[IDX_LSB +: IDX_W];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_data};
            s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// File: sser_regs.sv
/*
 * Status, error and secondary-sensor data register bank.
 * Holds identity, error_report, sensor_status and seven secondary data
 * bytes, plus a control word for a soft reset.
 * Assumes event inputs are one-cycle pulses and level inputs are
 * synchronous to aclk; the bus master follows AXI4-Lite.
 */
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ns

// Overview of operation
// - identity register at index 0x00 returns a fixed code on every read
// - fatal error bit 0 sets on boot/power failure, cleared only by reset
// - command error bit 1 sets whenever a host command fails
// - bits 4..2 hold a persistent error code, 0 none, 1 accel config
// - bit 6 sets on FIFO stream discard, clears when error register read
// - bit 7 sets on secondary master error, clears on error register read
// - status bit 4 is 0 while a command runs, 1 when ready; reset 0x10
// - status bit 2 is 1 while a manual secondary operation is ongoing
// - status bit 5 sets on new secondary data, clears on secondary read
// - status bit 7 sets on new accel data, clears on accel data read
// - secondary bytes x,y,z little-endian at 0x0A..0x0F, r low at 0x10
module sser_regs
    import sser_pkg::*;
#(
    parameter sser_pkg::sser_byte_t PART_IDENTITY_CODE =
        sser_pkg::PART_IDENTITY_DEFAULT
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [sser_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [sser_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [sser_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [sser_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic fatal_event,
    input wire logic soft_reset_cmd,
    input wire logic cmd_fail_event,
    input wire logic cmd_busy,
    input wire logic [2:0] error_code_in,
    input wire logic fifo_discard_event,
    input wire logic secondary_error_event,
    input wire logic secondary_manual_op_active,
    input wire logic secondary_data_valid,
    input wire logic [8*sser_pkg::SECONDARY_BYTES-1:0] secondary_data_in,
    input wire logic accel_data_valid,
    input wire logic accel_data_read,
    output logic soft_reset_pulse
);

    // ----------
    // bus front end
    // ----------
    logic wr_en;
    sser_idx_t wr_idx;
    sser_byte_t wr_byte;
    logic wr_lane0;
    logic wr_ok;
    logic rd_en;
    sser_idx_t rd_idx;
    sser_byte_t rd_data;
    logic rd_ok;

    sser_axil_slave u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_en(wr_en),
        .wr_idx(wr_idx),
        .wr_byte(wr_byte),
        .wr_lane0(wr_lane0),
        .wr_ok(wr_ok),
        .rd_en(rd_en),
        .rd_idx(rd_idx),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );

    // ----------
    // decode helpers
    // ----------
    function automatic logic is_secondary(input sser_idx_t idx);
        return idx >= IDX_SECONDARY_X_LOW && idx <= IDX_SECONDARY_R_LOW;
    endfunction

    function automatic logic is_mapped(input sser_idx_t idx);
        return idx == IDX_PART_IDENTITY || idx == IDX_ERROR_REPORT ||
            idx == IDX_SENSOR_STATUS || idx == IDX_BANK_CONTROL ||
            is_secondary(idx);
    endfunction

    logic rd_error_report;
    logic rd_secondary;
    logic ctrl_write;
    logic soft_reset_now;

    assign rd_error_report = rd_en && rd_idx == IDX_ERROR_REPORT;
    assign rd_secondary = rd_en && is_secondary(rd_idx);
    assign ctrl_write = wr_en && wr_lane0 && wr_idx == IDX_BANK_CONTROL;
    assign soft_reset_now = soft_reset_cmd ||
        (ctrl_write && wr_byte[CTRL_SOFT_RESET_BIT]);

    // writes to read-only registers are accepted and dropped
    assign wr_ok = is_mapped(wr_idx);
    assign rd_ok = is_mapped(rd_idx);

    // ----------
    // soft reset strobe
    // ----------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            soft_reset_pulse <= 1'b0;
        end else begin
            soft_reset_pulse <= soft_reset_now;
        end
    end

    // ----------
    // error_report flags
    // ----------
    logic fatal_err;
    logic cmd_err;
    logic fifo_err;
    logic secondary_err;
    logic [2:0] error_code;

    sser_sticky_flag u_fatal (
        .aclk(aclk),
        .aresetn(aresetn),
        .set(fatal_event),
        .clr(soft_reset_now),
        .q(fatal_err)
    );

    sser_sticky_flag u_cmd (
        .aclk(aclk),
        .aresetn(aresetn),
        .set(cmd_fail_event),
        .clr(soft_reset_now),
        .q(cmd_err)
    );

    sser_sticky_flag u_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .set(fifo_discard_event),
        .clr(rd_error_report || soft_reset_now),
        .q(fifo_err)
    );

    sser_sticky_flag u_sec_err (
        .aclk(aclk),
        .aresetn(aresetn),
        .set(secondary_error_event),
        .clr(rd_error_report || soft_reset_now),
        .q(secondary_err)
    );

    // persistent code follows its source, no clear on read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            error_code <= ERR_CODE_NONE;
        end else begin
            error_code <= error_code_in;
        end
    end

    // ----------
    // sensor_status flags
    // ----------
    logic cmd_ready;
    logic manual_op;
    logic drdy_secondary;
    logic drdy_accel;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd_ready <= SENSOR_STATUS_RESET[STAT_CMD_RDY_BIT];
        end else begin
            cmd_ready <= !cmd_busy;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            manual_op <= SENSOR_STATUS_RESET[STAT_MAN_OP_BIT];
        end else begin
            manual_op <= secondary_manual_op_active;
        end
    end

    sser_sticky_flag u_drdy_sec (
        .aclk(aclk),
        .aresetn(aresetn),
        .set(secondary_data_valid),
        .clr(rd_secondary),
        .q(drdy_secondary)
    );

    sser_sticky_flag u_drdy_acc (
        .aclk(aclk),
        .aresetn(aresetn),
        .set(accel_data_valid),
        .clr(accel_data_read),
        .q(drdy_accel)
    );

    // ----------
    // secondary data bytes
    // ----------
    sser_byte_t secondary_data [SECONDARY_BYTES];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < SECONDARY_BYTES; i++) begin
                secondary_data[i] <= SECONDARY_RESET;
            end
        end else if (secondary_data_valid) begin
            for (int i = 0; i < SECONDARY_BYTES; i++) begin
                secondary_data[i] <= secondary_data_in[8*i +: 8];
            end
        end
    end

    // ----------
    // register images and read mux
    // ----------
    sser_byte_t error_report;
    sser_byte_t sensor_status;
    sser_idx_t sec_offset;

    always_comb begin
        error_report = ERROR_REPORT_RESET;
        error_report[ERR_FATAL_BIT] = fatal_err;
        error_report[ERR_CMD_BIT] = cmd_err;
        error_report[ERR_CODE_MSB:ERR_CODE_LSB] = error_code;
        error_report[ERR_FIFO_BIT] = fifo_err;
        error_report[ERR_AUX_BIT] = secondary_err;
    end

    always_comb begin
        sensor_status = 8'h00;
        sensor_status[STAT_MAN_OP_BIT] = manual_op;
        sensor_status[STAT_CMD_RDY_BIT] = cmd_ready;
        sensor_status[STAT_DRDY_SEC_BIT] = drdy_secondary;
        sensor_status[STAT_DRDY_ACC_BIT] = drdy_accel;
    end

    assign sec_offset = rd_idx - IDX_SECONDARY_X_LOW;

    always_comb begin
        rd_data = 8'h00;
        if (rd_idx == IDX_PART_IDENTITY) begin
            rd_data = PART_IDENTITY_CODE;
        end else if (rd_idx == IDX_ERROR_REPORT) begin
            rd_data = error_report;
        end else if (rd_idx == IDX_SENSOR_STATUS) begin
            rd_data = sensor_status;
        end else if (is_secondary(rd_idx)) begin
            rd_data = secondary_data[sec_offset[2:0]];
        end
    end

endmodule

// File: sser_regs_properties.sv
/*
 * Checker for the status, error and secondary-data bank read fields.
 * Assumes it is bound to sser_regs and sees only that module's ports.
 */
`timescale 1ns/1ns
module sser_regs_chk
    import sser_pkg::*;
#(
    parameter sser_pkg::sser_byte_t PART_IDENTITY_CODE = 8'h5A
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [sser_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [sser_pkg::DATA_W-1:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic fatal_event,
    input wire logic soft_reset_cmd,
    input wire logic cmd_fail_event,
    input wire logic cmd_busy,
    input wire logic [2:0] error_code_in,
    input wire logic fifo_discard_event,
    input wire logic secondary_error_event,
    input wire logic secondary_manual_op_active,
    input wire logic secondary_data_valid,
    input wire logic [8*sser_pkg::SECONDARY_BYTES-1:0] secondary_data_in,
    input wire logic accel_data_valid,
    input wire logic accel_data_read,
    input wire logic soft_reset_pulse
);
    // ----------
    // flag model and snapshot at each read take
    // ----------
    sser_idx_t ai, q_idx;
    logic [7:0] m, q_err, q_sta, q_byte;
    logic [4:0] lv;
    logic [55:0] sec;
    logic take, clr, err_rd, sec_rd, rv_err, rv_sta;
    assign ai = s_axi_araddr[7:2];
    assign take = s_axi_arvalid && s_axi_arready;
    assign clr = soft_reset_cmd || soft_reset_pulse;
    assign err_rd = take && ai == IDX_ERROR_REPORT;
    assign sec_rd = take && ai >= 6'h0A && ai <= 6'h10;
    assign rv_err = s_axi_rvalid && q_idx == IDX_ERROR_REPORT;
    assign rv_sta = s_axi_rvalid && q_idx == IDX_SENSOR_STATUS;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            m <= 8'h00;
            lv <= 5'h00;
            sec <= '0;
        end else begin
            m[0] <= fatal_event || (m[0] && !clr);
            m[1] <= cmd_fail_event || (m[1] && !clr);
            m[6] <= fifo_discard_event || (m[6] && !clr && !err_rd);
            m[7] <= secondary_error_event || (m[7] && !clr && !err_rd);
            m[2] <= secondary_data_valid || (m[2] && !sec_rd);
            m[3] <= accel_data_valid || (m[3] && !accel_data_read);
            lv <= {cmd_busy, secondary_manual_op_active, error_code_in};
            if (secondary_data_valid) begin
                sec <= secondary_data_in;
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (take) begin
            q_idx <= ai;
            q_err <= {m[7:6], 1'b0, lv[2:0], m[1:0]};
            q_sta <= {m[3], 1'b0, m[2], !lv[4], 1'b0, lv[3], 2'b00};
            q_byte <= 8'(sec >> {ai - 6'h0A, 3'h0});
        end
    end
    // ----------
    // assertions
    // ----------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_IDENTITY: assert property (s_axi_rvalid && q_idx == 6'h00
        |-> s_axi_rdata[7:0] == PART_IDENTITY_CODE) else $error("id bad");
    AST_FATAL: assert property (rv_err |-> s_axi_rdata[0] == q_err[0])
        else $error("fatal flag bad");
    AST_CMD_ERR: assert property (rv_err |-> s_axi_rdata[1] == q_err[1])
        else $error("cmd error bad");
    AST_CODE: assert property (rv_err |-> s_axi_rdata[4:2] == q_err[4:2])
        else $error("error code bad");
    AST_FIFO_ERR: assert property (err_rd |=> s_axi_rdata[6] == q_err[6])
        else $error("fifo flag bad");
    AST_AUX_ERR: assert property (err_rd ##1 s_axi_rvalid
        |-> s_axi_rdata[7] == $past(m[7])) else $error("sec error bad");
    AST_CMD_RDY: assert property (rv_sta |-> s_axi_rdata[4] == q_sta[4])
        else $error("ready bit bad");
    AST_MAN_OP: assert property (rv_sta |-> s_axi_rdata[2] == q_sta[2])
        else $error("manual op bit bad");
    AST_DRDY_SEC: assert property (rv_sta |-> s_axi_rdata[5] == q_sta[5])
        else $error("sec ready bad");
    AST_DRDY_ACC: assert property ($rose(s_axi_rvalid) && q_idx == 6'h03
        |-> s_axi_rdata[7] == q_sta[7]) else $error("acc ready bad");
    AST_SEC_DATA: assert property (s_axi_rvalid && q_idx >= 6'h0A
        && q_idx <= 6'h10 |-> s_axi_rdata == {24'h0, q_byte})
        else $error("sec byte bad");
    AST_RESERVED: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 0
        && !(rv_err && s_axi_rdata[5]) && !(rv_sta && |(s_axi_rdata & 8'h4B)))
        else $error("reserved bits set");
endmodule

bind sser_regs sser_regs_chk #(
    .PART_IDENTITY_CODE(PART_IDENTITY_CODE)
) chk (.*);

// File: sser_host_model.sv
/*
 * Host model: AXI4-Lite master doing single reads and writes.
 * Assumes one clock; stall holds rready off for that many cycles.
 */
`timescale 1ns/1ns
module sser_host_model
    import sser_pkg::*;
(
    input wire logic aclk,
    output logic [sser_pkg::ADDR_W-1:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [sser_pkg::DATA_W-1:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [sser_pkg::ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [sser_pkg::DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    int stall = 0;
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~d;
            end
            if (s_axi_bvalid && s_axi_bready) break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= (stall == 0);
        forever begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~a;
            end
            if (s_axi_rvalid && s_axi_rready) break;
            if (n >= stall) s_axi_rready <= 1'b1;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule

// File: tb_top.sv
/*
 * Self-checking bench for the register bank, one task per scenario.
 * Assumes the host model and the bound checker are compiled alongside.
 */
`timescale 1ns/1ns
module tb_top;
    import sser_pkg::*;
    localparam sser_byte_t TB_ID = 8'hC3; // arbitrary identity value
    logic aclk, aresetn, soft_reset_pulse;
    logic [7:0] s_axi_awaddr, s_axi_araddr, evs;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, cmd_busy, secondary_manual_op_active;
    logic fatal_event, soft_reset_cmd, cmd_fail_event, fifo_discard_event;
    logic secondary_error_event, secondary_data_valid;
    logic accel_data_valid, accel_data_read;
    logic [2:0] error_code_in;
    logic [55:0] secondary_data_in;
    int failures = 0;
    int checks_done = 0;
    assign {fatal_event, soft_reset_cmd, cmd_fail_event, fifo_discard_event,
        secondary_error_event, secondary_data_valid, accel_data_valid,
        accel_data_read} = evs;
    sser_regs #(.PART_IDENTITY_CODE(TB_ID)) dut (.*);
    sser_host_model host (.*);
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    // ----------
    // shared tasks
    // ----------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rdo(input sser_idx_t i, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        host.rd({i, 2'b00}, d, r);
        chk(d, e);
        chk(32'(r), 32'(RESP_OKAY));
    endtask
    task automatic pulse(input logic [7:0] v);
        @(posedge aclk);
        evs <= v;
        @(posedge aclk);
        evs <= 8'h00;
    endtask
    task automatic tally_and_finish();
        $display("checks_done=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ----------
    // scenarios
    // ----------
    task automatic t_ro();
        logic [1:0] r;
        rdo(IDX_SENSOR_STATUS, 32'h10);
        host.wr(8'h00, 32'hFF, r);
        chk(32'(r), 32'(RESP_OKAY));
        host.wr(8'h08, 32'hFF, r);
        host.wr(8'h0C, 32'hEF, r);
        host.wr(8'h28, 32'hFF, r);
        rdo(IDX_PART_IDENTITY, 32'(TB_ID));
        rdo(IDX_ERROR_REPORT, 32'h00);
        rdo(IDX_SENSOR_STATUS, 32'h10);
        for (int i = 0; i < 7; i++) begin
            rdo(IDX_SECONDARY_X_LOW + 6'(i), 32'h00);
        end
    endtask
    task automatic t_err();
        @(posedge aclk);
        error_code_in <= ERR_CODE_ACCEL_CONF;
        pulse(8'hB8);
        rdo(IDX_ERROR_REPORT, 32'hC7);
        rdo(IDX_ERROR_REPORT, 32'h07);
        error_code_in <= ERR_CODE_NONE;
        rdo(IDX_ERROR_REPORT, 32'h03);
        pulse(8'h40);
        repeat (3) @(posedge aclk);
        rdo(IDX_ERROR_REPORT, 32'h00);
    endtask
    task automatic t_status();
        @(posedge aclk);
        cmd_busy <= 1'b1;
        secondary_manual_op_active <= 1'b1;
        rdo(IDX_SENSOR_STATUS, 32'h04);
        cmd_busy <= 1'b0;
        secondary_manual_op_active <= 1'b0;
        rdo(IDX_SENSOR_STATUS, 32'h10);
        pulse(8'h02);
        rdo(IDX_SENSOR_STATUS, 32'h90);
        rdo(IDX_SENSOR_STATUS, 32'h90);
        pulse(8'h01);
        rdo(IDX_SENSOR_STATUS, 32'h10);
    endtask
    task automatic t_sec();
        @(posedge aclk);
        secondary_data_in <= 56'hD7C6B5A4938271;
        pulse(8'h04);
        rdo(IDX_SENSOR_STATUS, 32'h30);
        host.stall = 3;
        rdo(IDX_SECONDARY_Y_HIGH, 32'hA4);
        host.stall = 0;
        rdo(IDX_SENSOR_STATUS, 32'h10);
        for (int i = 0; i < 7; i++) begin
            rdo(6'h0A + 6'(i), 32'(8'h71 + 8'(i) * 8'h11));
        end
        pulse(8'h04);
        rdo(IDX_SECONDARY_R_LOW, 32'hD7);
        rdo(IDX_SENSOR_STATUS, 32'h10);
    endtask
    task automatic t_bad();
        logic [31:0] d;
        logic [1:0] r;
        host.rd(8'h44, d, r);
        chk(32'(r), 32'(RESP_SLVERR));
        chk(d, 32'h0);
        host.rd(8'h04, d, r);
        chk(32'(r), 32'(RESP_SLVERR));
        host.wr(8'h44, 32'h1, r);
        chk(32'(r), 32'(RESP_SLVERR));
        pulse(8'h80);
        host.wr(8'hFC, 32'h1, r);
        chk(32'(soft_reset_pulse), 32'h1);
        repeat (3) @(posedge aclk);
        rdo(IDX_ERROR_REPORT, 32'h00);
        pulse(8'h84);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rdo(IDX_ERROR_REPORT, 32'h00);
        rdo(IDX_SENSOR_STATUS, 32'h10);
    endtask
    // ----------
    // main sequence and watchdog
    // ----------
    initial begin
        aresetn = 1'b0;
        evs = 8'h00;
        {cmd_busy, secondary_manual_op_active} = 2'b00;
        error_code_in = 3'h0;
        secondary_data_in = '0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_ro();
        t_err();
        t_status();
        t_sec();
        t_bad();
        tally_and_finish();
    end
    initial begin
        repeat (5000) @(posedge aclk);
        failures++;
        tally_and_finish();
    end
endmodule
